// *** tb_unlock_guard.sv ***
// self-checking bench for the timed write unlock guard
`timescale 1ns/1ps
`include "unlock_guard_defines.vh"
module tb_unlock_guard;
  logic        i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, rerr;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, rdat;
  wire         o_pready, o_pslverr, o_wait_state_en, o_por_flag, o_window_open;
  wire  [31:0] o_prdata;
  wire  [3:0]  o_watchdog_ctrl;
  wire  [1:0]  o_rom_size;
  int n_mismatch = 0, total_checks = 0;
  // short machine cycle keeps the run brief
  unlock_guard #(.CLK_PER_MC(2)) u_unlock_guard (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_watchdog_ctrl(o_watchdog_ctrl), .o_rom_size(o_rom_size),
    .o_wait_state_en(o_wait_state_en), .o_por_flag(o_por_flag), .o_window_open(o_window_open));
  initial forever #2 i_clk = ~i_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready is seen
  task xf(input logic w, input logic [11:0] a, input logic [7:0] d);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= {24'h0, d};
    @(posedge i_clk) i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rdat = o_prdata;
    rerr = o_pslverr;
  endtask
  task gap(input int c);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    repeat (c) @(posedge i_clk);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, tests need about 80 cycles
  initial begin #2000; n_mismatch++; close_out; end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    xf(0, `PROT_REG_ADDR, 8'h00); chk(rdat, `PROT_RESET);
    xf(1, `PROT_REG_ADDR, 8'h7F); xf(0, `PROT_REG_ADDR, 8'h00); chk(rdat, `PROT_RESET);
    xf(1, `KEY_REG_ADDR, `KEY_FIRST); xf(1, `KEY_REG_ADDR, `KEY_SECOND);
    chk(o_window_open, 1);
    xf(1, `PROT_REG_ADDR, 8'h4F); chk({o_por_flag, o_wait_state_en, o_rom_size, o_watchdog_ctrl}, 8'h4F);
    gap(8); chk(o_window_open, 0);
    xf(1, `PROT_REG_ADDR, 8'hFF); xf(0, `PROT_REG_ADDR, 8'h00); chk(rdat, 32'h4F);
    xf(1, `KEY_REG_ADDR, `KEY_SECOND); chk(o_window_open, 0);
    xf(1, `KEY_REG_ADDR, `KEY_FIRST); xf(1, `KEY_REG_ADDR, 8'h12); xf(1, `KEY_REG_ADDR, `KEY_SECOND);
    chk(o_window_open, 0);
    xf(1, `KEY_REG_ADDR, `KEY_FIRST); gap(8); xf(1, `KEY_REG_ADDR, `KEY_SECOND); chk(o_window_open, 0);
    xf(0, `KEY_REG_ADDR, 8'h00); chk(rdat, 0);
    xf(1, 12'h100, 8'h5A); chk(rerr, 1);
    xf(0, 12'h100, 8'h00); chk({rerr, rdat[30:0]}, 32'h80000000);
    gap(1);
    close_out;
  end
endmodule // tb_unlock_guard
bind unlock_guard unlock_guard_props #(.CLK_PER_MC(CLK_PER_MC), .OPEN_MC(OPEN_MC)) u_unlock_guard_props (.*);

// *** unlock_guard.v ***
// timed write unlock guard with apb register slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "unlock_guard_defines.vh"
module unlock_guard #(
  parameter CLK_PER_MC = `CLK_PER_MC,
  parameter WAIT_MC    = `WAIT_MC,
  parameter OPEN_MC    = `OPEN_MC
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg         o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  output reg  [3:0]  o_watchdog_ctrl,
  output reg  [1:0]  o_rom_size,
  output reg         o_wait_state_en,
  output reg         o_por_flag,
  output reg         o_window_open
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_OPEN = 3'b100;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [7:0]  mc_div_ff;
  reg  [7:0]  mc_left_ff;
  reg  [7:0]  nxt_mc_left;
  reg  [7:0]  prot_ff;
  reg  [7:0]  nxt_prot;
  reg         acc_done_ff;
  wire        setup_ok;
  wire        wr_key;
  wire        wr_prot;
  wire        mc_tick;

  // how the guard behaves, seen from software:
  // - the key register takes two values in a row, first key then second key
  // - the first key arms a short wait, counted in machine cycles
  // - the second key inside that wait opens the write window
  // - any other key value, or a second key with nothing armed, drops it all
  // - while the window is open the protected register takes writes
  // - outside the window such writes answer normally but change nothing
  // - the window shuts by itself once its machine cycles have run out
  //
  // timing notes:
  // - a machine cycle is CLK_PER_MC clocks, made by a free running divider
  // - counts decrement on divider ticks, not from the write itself,
  //   so the real wait and open spans lie between N-1 and N machine cycles
  // - this trades exactness for one shared divider instead of one per count
  // - software that follows the first key at once with the second key
  //   is always inside the wait, whatever the divider phase
  //
  // bus notes:
  // - every access phase takes two cycles, pready comes one cycle late
  // - acc_done_ff stops a held access from being taken again in the cycle that pready is high
  // - unmapped addresses answer with an error, writes there are dropped
  // - the key register reads zero so the keys never show on the bus
  //
  // hazard: a first key written while the window is open closes it,
  // so a sequence restarted in the middle of an update loses the window

  // address decode, used by the write strobes, the error flag and read data
  function is_key;
    input [11:0] addr;
    begin
      is_key = (addr == `KEY_REG_ADDR);
    end
  endfunction

  function is_prot;
    input [11:0] addr;
    begin
      is_prot = (addr == `PROT_REG_ADDR);
    end
  endfunction

  function is_stat;
    input [11:0] addr;
    begin
      is_stat = (addr == `STAT_REG_ADDR);
    end
  endfunction

  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = is_key(addr) | is_prot(addr) | is_stat(addr);
    end
  endfunction

  // apb access phase answered one cycle after it starts
  assign setup_ok = i_psel & i_penable & ~acc_done_ff;
  assign wr_key   = setup_ok & i_pwrite & is_key(i_paddr);  // RULE_02
  assign wr_prot  = setup_ok & i_pwrite & is_prot(i_paddr);
  assign mc_tick  = (mc_div_ff == CLK_PER_MC[7:0] - 8'h01);

  // machine cycle divider, free running
  always @(posedge i_clk) begin
    if (!i_rst_n)
      mc_div_ff <= 8'h00;
    else if (mc_tick)
      mc_div_ff <= 8'h00;
    else
      mc_div_ff <= mc_div_ff + 8'h01;
  end

  // key sequencer; cycle counts start at the next machine cycle boundary
  always @* begin
    nxt_state   = state_ff;
    nxt_mc_left = mc_left_ff;
    if (wr_key) begin
      if (i_pwdata[7:0] == `KEY_FIRST) begin
        nxt_state   = ST_WAIT;  // RULE_03
        nxt_mc_left = WAIT_MC[7:0];
      end else if (i_pwdata[7:0] == `KEY_SECOND && state_ff == ST_WAIT) begin
        nxt_state   = ST_OPEN;  // RULE_04
        nxt_mc_left = OPEN_MC[7:0];  // RULE_05
      end else begin
        nxt_state   = ST_IDLE;  // RULE_09
        nxt_mc_left = 8'h00;
      end
    end else if (mc_tick) begin
      case (state_ff)
        ST_WAIT,
        ST_OPEN: begin
          if (mc_left_ff <= 8'h01) begin
            nxt_state   = ST_IDLE;  // RULE_06
            nxt_mc_left = 8'h00;
          end else begin
            nxt_mc_left = mc_left_ff - 8'h01;
          end
        end
        default: begin
          nxt_state   = ST_IDLE;
          nxt_mc_left = 8'h00;
        end
      endcase
    end
  end

  // protected bits: watchdog, rom size, wait state, reset flag
  always @* begin
    nxt_prot = prot_ff;
    if (wr_prot && state_ff == ST_OPEN)  // RULE_01 RULE_08
      nxt_prot = i_pwdata[7:0];
  end

  // sequencer and protected register; reset drops any pending key
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff   <= ST_IDLE;  // RULE_09
      mc_left_ff <= 8'h00;
      prot_ff    <= `PROT_RESET;
    end else begin
      state_ff   <= nxt_state;
      mc_left_ff <= nxt_mc_left;
      prot_ff    <= nxt_prot;
    end
  end

  // apb answer; pready is a one cycle pulse, never two in a row
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc_done_ff <= 1'b0;
      o_pready    <= 1'b0;
      o_pslverr   <= 1'b0;
    end else begin
      acc_done_ff <= setup_ok;
      o_pready    <= setup_ok;
      o_pslverr   <= setup_ok & ~is_mapped(i_paddr);
    end
  end

  // read data; key register is write only and reads zero
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
    end else if (setup_ok && !i_pwrite) begin
      if (is_prot(i_paddr))
        o_prdata <= {24'h000000, prot_ff};
      else if (is_stat(i_paddr))
        o_prdata <= {24'h000000, mc_left_ff[3:0], 1'b0, state_ff};
      else
        o_prdata <= 32'h00000000;
    end
  end

  // protected copies follow the next value, so they never lag the register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_watchdog_ctrl <= 4'h0;
      o_rom_size      <= 2'h0;
      o_wait_state_en <= 1'b0;
      o_por_flag      <= 1'b1;
    end else begin
      o_watchdog_ctrl <= nxt_prot[`WD_CTRL_LSB +: `WD_CTRL_W];  // RULE_08
      o_rom_size      <= nxt_prot[`ROM_SIZE_LSB +: `ROM_SIZE_W];
      o_wait_state_en <= nxt_prot[`WAIT_STATE_BIT];
      o_por_flag      <= nxt_prot[`POR_FLAG_BIT];
    end
  end

  // window flag, high exactly while writes to protected bits land
  always @(posedge i_clk) begin
    if (!i_rst_n)
      o_window_open <= 1'b0;
    else
      o_window_open <= (nxt_state == ST_OPEN);  // RULE_05
  end
endmodule // unlock_guard

// *** unlock_guard_defines.vh ***
// constants for the timed write unlock guard
//
// Overview of operation
// (RULE_01) protected writes only land while window open
// (RULE_02) key register sits at address C7h; code decodes APB address 31Ch, word index C7h
// (RULE_03) AAh write starts three-cycle wait for 55h; code waits between two and three machine cycles
// (RULE_04) timely 55h write opens the window
// (RULE_05) window stays open three machine cycles; code keeps it open between two and three, counted on divider ticks
// (RULE_06) window closes by itself afterwards
// (RULE_07) software writes AAh then 55h each time
// (RULE_08) guard covers watchdog, rom size, wait, reset flag
// (RULE_09) stray key writes or reset abandon everything
`ifndef UNLOCK_GUARD_DEFINES_VH
`define UNLOCK_GUARD_DEFINES_VH
`define KEY_REG_ADDR    12'h31C
`define KEY_REG_INDEX   8'hC7
`define PROT_REG_ADDR   12'h320
`define STAT_REG_ADDR   12'h324
`define KEY_FIRST       8'hAA
`define KEY_SECOND      8'h55
`define WAIT_MC         3
`define OPEN_MC         3
`define CLK_PER_MC      12
`define WD_CTRL_LSB     0
`define WD_CTRL_W       4
`define ROM_SIZE_LSB    4
`define ROM_SIZE_W      2
`define WAIT_STATE_BIT  6
`define POR_FLAG_BIT    7
`define PROT_RESET      8'h80
`endif

// *** unlock_guard_props.sv ***
// assertions on the ports of the timed write unlock guard
`timescale 1ns/1ps
`include "unlock_guard_defines.vh"
module unlock_guard_props #(
  parameter CLK_PER_MC = 2,
  parameter OPEN_MC    = 3
) (
  input wire        i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata, o_prdata,
  input wire [3:0]  o_watchdog_ctrl,
  input wire [1:0]  o_rom_size,
  input wire        o_wait_state_en, o_por_flag, o_window_open
);
  localparam int LIM = CLK_PER_MC * OPEN_MC;
  logic [7:0] open_ff;
  // completed write to the key register
  wire kw = o_pready && i_pwrite && i_paddr == `KEY_REG_ADDR;
  // run length of the open window, too long a window is the hazard
  always @(posedge i_clk) open_ff <= o_window_open ? open_ff + 8'h01 : 8'h00;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_ans; i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready; endproperty
  a_ans: assert property (p_ans) else $error("access phase length wrong");
  property p_pls; o_pready |=> !o_pready; endproperty
  a_pls: assert property (p_pls) else $error("pready longer than one cycle");
  property p_err; o_pready && !(i_paddr inside {`KEY_REG_ADDR, `PROT_REG_ADDR, `STAT_REG_ADDR}) |-> o_pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access without error");
  property p_key; o_pready && !i_pwrite && i_paddr == `KEY_REG_ADDR |-> o_prdata == 32'h0; endproperty
  a_key: assert property (p_key) else $error("key register read not zero");
  property p_open; $rose(o_window_open) |-> kw && i_pwdata[7:0] == `KEY_SECOND; endproperty
  a_open: assert property (p_open) else $error("window opened without second key");
  property p_bad; kw && i_pwdata[7:0] != `KEY_SECOND |-> !o_window_open; endproperty
  a_bad: assert property (p_bad) else $error("window open after stray key");
  property p_prot; $changed({o_por_flag, o_wait_state_en, o_rom_size, o_watchdog_ctrl}) |-> $past(o_window_open); endproperty
  a_prot: assert property (p_prot) else $error("protected bits changed while closed");
  property p_len; open_ff <= LIM; endproperty
  a_len: assert property (p_len) else $error("window stayed open too long");
endmodule // unlock_guard_props
